//--- verilog/dmbd_regs.vh
// constants for the multiplier and branch group instruction decoder
`ifndef DMBD_REGS_VH
`define DMBD_REGS_VH

// instruction word fields
`define DMBD_UPPER_HI     15
`define DMBD_UPPER_LO     8
`define DMBD_MODE_BIT     7
`define DMBD_ADDR_HI      6
`define DMBD_IMM_HI       12
`define DMBD_IMM_TAG_LO   13
`define DMBD_IMM_TAG      3'h5
`define DMBD_SHIFT_HI     1
`define DMBD_SHIFT_TAG    6'h02
`define DMBD_SHIFT_RESET  2'h0

// whole-word opcodes and the upper byte they share
`define DMBD_W_ADDPROD    16'hCE15
`define DMBD_W_LDACCPROD  16'hCE14
`define DMBD_W_SUBPROD    16'hCE16
`define DMBD_W_BRACC      16'hCE25
`define DMBD_U_CTRL       8'hCE

// upper-byte opcodes
`define DMBD_U_LDPHI      8'h53
`define DMBD_U_LDMUL      8'h3C
`define DMBD_U_LDMULACC   8'h3D
`define DMBD_U_LDMULCPY   8'h3E
`define DMBD_U_LDMULMOV   8'h3F
`define DMBD_U_LDMULSUB   8'h5B
`define DMBD_U_MULACC     8'h5D
`define DMBD_U_MULACCMOV  8'h5C
`define DMBD_U_MUL        8'h38
`define DMBD_U_MULADD     8'h3A
`define DMBD_U_MULSUB     8'h3B
`define DMBD_U_MULUNS     8'hCF
`define DMBD_U_SQADD      8'h39
`define DMBD_U_SQSUB      8'h5A
`define DMBD_U_STPHI      8'h7D
`define DMBD_U_STPLO      8'h7C
`define DMBD_U_BUNC       8'hFF
`define DMBD_U_BAUX       8'hFB
`define DMBD_U_BNONNEG    8'hF4
`define DMBD_U_BPOS       8'hF1
`define DMBD_U_BNONPOS    8'hF2
`define DMBD_U_BNEG       8'hF3
`define DMBD_U_BNONZERO   8'hF5
`define DMBD_U_BFSET      8'hF9
`define DMBD_U_BFCLR      8'hF8
`define DMBD_U_BNOOVF     8'hF7
`define DMBD_U_BCSET      8'h5E
`define DMBD_U_BCCLR      8'h5F
`define DMBD_U_BIOLOW     8'hFA

// operation select codes
`define DMBD_OP_NONE      6'h00
`define DMBD_OP_ADDPROD   6'h01
`define DMBD_OP_LDACCPROD 6'h02
`define DMBD_OP_SUBPROD   6'h03
`define DMBD_OP_LDPHI     6'h04
`define DMBD_OP_LDMUL     6'h05
`define DMBD_OP_LDMULACC  6'h06
`define DMBD_OP_LDMULCPY  6'h07
`define DMBD_OP_LDMULMOV  6'h08
`define DMBD_OP_LDMULSUB  6'h09
`define DMBD_OP_MULACC    6'h0A
`define DMBD_OP_MULACCMOV 6'h0B
`define DMBD_OP_MUL       6'h0C
`define DMBD_OP_MULADD    6'h0D
`define DMBD_OP_MULSUB    6'h0E
`define DMBD_OP_MULUNS    6'h0F
`define DMBD_OP_MULIMM    6'h10
`define DMBD_OP_SQADD     6'h11
`define DMBD_OP_SQSUB     6'h12
`define DMBD_OP_STPHI     6'h13
`define DMBD_OP_STPLO     6'h14
`define DMBD_OP_SETSHIFT  6'h15
`define DMBD_OP_BRACC     6'h16
`define DMBD_OP_BUNC      6'h17
`define DMBD_OP_BAUX      6'h18
`define DMBD_OP_BNONNEG   6'h19
`define DMBD_OP_BPOS      6'h1A
`define DMBD_OP_BNONPOS   6'h1B
`define DMBD_OP_BNEG      6'h1C
`define DMBD_OP_BNONZERO  6'h1D
`define DMBD_OP_BFSET     6'h1E
`define DMBD_OP_BFCLR     6'h1F
`define DMBD_OP_BNOOVF    6'h20
`define DMBD_OP_BCSET     6'h21
`define DMBD_OP_BCCLR     6'h22
`define DMBD_OP_BIOLOW    6'h23

`endif

//--- verilog/dmbd_opcode_table.v
// first-word opcode lookup for the multiplier and branch groups
`timescale 1ns/10ps
`include "dmbd_regs.vh"

module dmbd_opcode_table (
	input  wire [15:0] word,
	output reg  [5:0]  opSel,
	output reg         twoWord,
	output reg         memRef,
	output reg         isBranch,
	output reg         known
);
	wire [7:0] upper;
	assign upper = word[`DMBD_UPPER_HI:`DMBD_UPPER_LO];

	always @* begin
		opSel    = `DMBD_OP_NONE;
		twoWord  = 1'b0;
		memRef   = 1'b1;
		isBranch = 1'b0;
		case (upper)
		`DMBD_U_LDPHI:     opSel = `DMBD_OP_LDPHI;
		`DMBD_U_LDMUL:     opSel = `DMBD_OP_LDMUL;
		`DMBD_U_LDMULACC:  opSel = `DMBD_OP_LDMULACC;
		`DMBD_U_LDMULCPY:  opSel = `DMBD_OP_LDMULCPY;
		`DMBD_U_LDMULMOV:  opSel = `DMBD_OP_LDMULMOV;
		`DMBD_U_LDMULSUB:  opSel = `DMBD_OP_LDMULSUB;
		`DMBD_U_MUL:       opSel = `DMBD_OP_MUL;
		`DMBD_U_MULADD:    opSel = `DMBD_OP_MULADD;
		`DMBD_U_MULSUB:    opSel = `DMBD_OP_MULSUB;
		`DMBD_U_MULUNS:    opSel = `DMBD_OP_MULUNS;
		`DMBD_U_SQADD:     opSel = `DMBD_OP_SQADD;
		`DMBD_U_SQSUB:     opSel = `DMBD_OP_SQSUB;
		`DMBD_U_STPHI:     opSel = `DMBD_OP_STPHI;
		`DMBD_U_STPLO:     opSel = `DMBD_OP_STPLO;
		`DMBD_U_MULACC:    opSel = `DMBD_OP_MULACC;
		`DMBD_U_MULACCMOV: opSel = `DMBD_OP_MULACCMOV;
		`DMBD_U_BUNC:      opSel = `DMBD_OP_BUNC;
		`DMBD_U_BAUX:      opSel = `DMBD_OP_BAUX;
		`DMBD_U_BNONNEG:   opSel = `DMBD_OP_BNONNEG;
		`DMBD_U_BPOS:      opSel = `DMBD_OP_BPOS;
		`DMBD_U_BNONPOS:   opSel = `DMBD_OP_BNONPOS;
		`DMBD_U_BNEG:      opSel = `DMBD_OP_BNEG;
		`DMBD_U_BNONZERO:  opSel = `DMBD_OP_BNONZERO;
		`DMBD_U_BFSET:     opSel = `DMBD_OP_BFSET;
		`DMBD_U_BFCLR:     opSel = `DMBD_OP_BFCLR;
		`DMBD_U_BNOOVF:    opSel = `DMBD_OP_BNOOVF;
		`DMBD_U_BCSET:     opSel = `DMBD_OP_BCSET;
		`DMBD_U_BCCLR:     opSel = `DMBD_OP_BCCLR;
		`DMBD_U_BIOLOW:    opSel = `DMBD_OP_BIOLOW;
		`DMBD_U_CTRL: begin
			memRef = 1'b0;
			if (word == `DMBD_W_ADDPROD)
				opSel = `DMBD_OP_ADDPROD;
			else if (word == `DMBD_W_LDACCPROD)
				opSel = `DMBD_OP_LDACCPROD;
			else if (word == `DMBD_W_SUBPROD)
				opSel = `DMBD_OP_SUBPROD;
			else if (word == `DMBD_W_BRACC)
				opSel = `DMBD_OP_BRACC;
			else if (word[7:2] == `DMBD_SHIFT_TAG)
				opSel = `DMBD_OP_SETSHIFT;
		end
		default: begin
			memRef = 1'b0;
			if (word[`DMBD_UPPER_HI:`DMBD_IMM_TAG_LO] == `DMBD_IMM_TAG)
				opSel = `DMBD_OP_MULIMM;
		end
		endcase
		// two-word branch first words need bit 7 set; with it clear the word is foreign
		if (opSel >= `DMBD_OP_BUNC) begin
			isBranch = 1'b1;
			twoWord  = 1'b1;
			memRef   = 1'b0;
			if (!word[`DMBD_MODE_BIT])
				opSel = `DMBD_OP_NONE;
		end
		if (opSel == `DMBD_OP_BRACC)
			isBranch = 1'b1;
		if (opSel == `DMBD_OP_MULACC || opSel == `DMBD_OP_MULACCMOV)
			twoWord = 1'b1;
		if (opSel == `DMBD_OP_NONE) begin
			twoWord  = 1'b0;
			memRef   = 1'b0;
			isBranch = 1'b0;
		end
		known = (opSel != `DMBD_OP_NONE);
	end
endmodule

//--- verilog/dmbd_branch_cond.v
// branch condition evaluation from datapath status
`timescale 1ns/10ps
`include "dmbd_regs.vh"

module dmbd_branch_cond (
	input  wire [5:0]  opSel,
	input  wire [31:0] accValue,
	input  wire        auxNonzero,
	input  wire        testControlFlag,
	input  wire        overflowFlag,
	input  wire        carryFlag,
	input  wire        ioStatus,
	output reg         taken
);
	wire accZero;
	wire accNeg;
	assign accZero = (accValue == 32'h00000000);
	assign accNeg  = accValue[31];

	always @* begin
		case (opSel)
		`DMBD_OP_BRACC:    taken = 1'b1;
		`DMBD_OP_BUNC:     taken = 1'b1;
		`DMBD_OP_BAUX:     taken = auxNonzero;
		`DMBD_OP_BNONNEG:  taken = !accNeg;
		`DMBD_OP_BPOS:     taken = !accNeg && !accZero;
		`DMBD_OP_BNONPOS:  taken = accNeg || accZero;
		`DMBD_OP_BNEG:     taken = accNeg;
		`DMBD_OP_BNONZERO: taken = !accZero;
		`DMBD_OP_BFSET:    taken = testControlFlag;
		`DMBD_OP_BFCLR:    taken = !testControlFlag;
		`DMBD_OP_BNOOVF:   taken = !overflowFlag;
		`DMBD_OP_BCSET:    taken = carryFlag;
		`DMBD_OP_BCCLR:    taken = !carryFlag;
		`DMBD_OP_BIOLOW:   taken = !ioStatus;
		default:           taken = 1'b0;
		endcase
	end
endmodule

//--- verilog/dmbd_decoder.v
// multiplier and branch group instruction decoder, top level
//
// Notes on behaviour
// - opcode CE15 decodes as add product to accumulator, one word.
// - opcode CE14 decodes as copy product into accumulator, one word.
// - opcode CE16 decodes as subtract product from accumulator, one word.
// - upper byte 53 loads product high; bit 7 mode, bits 6-0 address.
// - upper bytes 3C-3F decode as the four multiplicand load variants.
// - upper byte 5B loads multiplicand and subtracts previous product.
// - upper bytes 5D, 5C are two-word multiply-accumulate; second word fetched.
// - upper bytes 38, 3A, 3B, CF decode as the multiply variants.
// - upper bytes 39 and 5A are square-add and square-subtract.
// - upper bytes 7D and 7C store product high and product low.
// - pattern CE08 plus two low bits sets product shift mode.
// - opcode CE25 branches to the address held in the accumulator.
// - FF80 and FB80 are two-word unconditional and aux-nonzero branches.
// - upper bytes F4, F1, F2, F3, F5 test accumulator sign and zero.
// - upper bytes F9 and F8 test the test-control flag set or clear.
// - upper bytes F7, 5E, 5F take no overflow, carry set, carry clear.
// - upper byte FA branches when the I/O status input is low.
`timescale 1ns/10ps
`include "dmbd_regs.vh"

module dmbd_decoder (
	input  wire        mclk,
	input  wire        rst,
	input  wire [15:0] instrWord,
	input  wire        instrValid,
	input  wire        flush,
	input  wire [31:0] accValue,
	input  wire        auxNonzero,
	input  wire        testControlFlag,
	input  wire        overflowFlag,
	input  wire        carryFlag,
	input  wire        ioStatus,
	output wire        instrReady,
	output wire        wantSecond,
	output reg         decodeValid,
	output reg  [5:0]  opSelect,
	output reg         indirectMode,
	output reg  [6:0]  directAddr,
	output reg  [12:0] immConst,
	output reg  [1:0]  shiftField,
	output reg         twoWordOp,
	output reg  [15:0] secondWord,
	output reg         isBranch,
	output reg         branchTaken,
	output reg  [15:0] branchTarget,
	output reg         memRef,
	output reg         illegalOp,
	output reg  [1:0]  productShiftMode
);
	localparam ST_FIRST  = 1'b0;
	localparam ST_SECOND = 1'b1;

	reg         state_reg;
	reg         state_next;
	reg  [15:0] held_reg;
	reg  [15:0] held_next;

	reg         valid_next;
	reg  [5:0]  op_next;
	reg         indirect_next;
	reg  [6:0]  addr_next;
	reg  [12:0] imm_next;
	reg  [1:0]  field_next;
	reg         two_next;
	reg  [15:0] second_next;
	reg         branch_next;
	reg         taken_next;
	reg  [15:0] target_next;
	reg         memref_next;
	reg         illegal_next;
	reg  [1:0]  pshift_next;

	// the word that is being decoded: the fresh one, or the held first word
	wire [15:0] firstWord;
	wire        accept;
	wire [5:0]  tabOp;
	wire        tabTwo;
	wire        tabMem;
	wire        tabBranch;
	wire        tabKnown;
	wire        condTaken;

	// the decoder never stalls fetch; ready only drops during reset
	assign instrReady = !rst;
	assign accept     = instrValid && instrReady && !flush;
	assign wantSecond = (state_reg == ST_SECOND);
	assign firstWord  = (state_reg == ST_SECOND) ? held_reg : instrWord;

	dmbd_opcode_table u_table (
		.word     (firstWord),
		.opSel    (tabOp),
		.twoWord  (tabTwo),
		.memRef   (tabMem),
		.isBranch (tabBranch),
		.known    (tabKnown)
	);

	// flags are sampled when the last word of the branch arrives
	dmbd_branch_cond u_cond (
		.opSel           (tabOp),
		.accValue        (accValue),
		.auxNonzero      (auxNonzero),
		.testControlFlag (testControlFlag),
		.overflowFlag    (overflowFlag),
		.carryFlag       (carryFlag),
		.ioStatus        (ioStatus),
		.taken           (condTaken)
	);

	always @* begin
		state_next    = state_reg;
		held_next     = held_reg;
		valid_next    = 1'b0;
		op_next       = opSelect;
		indirect_next = indirectMode;
		addr_next     = directAddr;
		imm_next      = immConst;
		field_next    = shiftField;
		two_next      = twoWordOp;
		second_next   = secondWord;
		branch_next   = isBranch;
		taken_next    = branchTaken;
		target_next   = branchTarget;
		memref_next   = memRef;
		illegal_next  = illegalOp;
		pshift_next   = productShiftMode;

		case (state_reg)
		ST_FIRST: begin
			if (accept) begin
				op_next       = tabOp;
				two_next      = tabTwo;
				branch_next   = tabBranch;
				memref_next   = tabMem;
				illegal_next  = !tabKnown;
				// mode bit and address field hold for every memory form
				indirect_next = instrWord[`DMBD_MODE_BIT];
				addr_next     = instrWord[`DMBD_ADDR_HI:0];
				imm_next      = instrWord[`DMBD_IMM_HI:0];
				field_next    = instrWord[`DMBD_SHIFT_HI:0];
				second_next   = 16'h0000;
				taken_next    = 1'b0;
				target_next   = 16'h0000;
				if (tabTwo) begin
					// finish only once the second word has been fetched
					held_next  = instrWord;
					state_next = ST_SECOND;
				end else begin
					valid_next = 1'b1;
					if (tabOp == `DMBD_OP_BRACC) begin
						taken_next  = condTaken;
						target_next = accValue[15:0];
					end
					if (tabOp == `DMBD_OP_SETSHIFT)
						pshift_next = instrWord[`DMBD_SHIFT_HI:0];
				end
			end
		end
		ST_SECOND: begin
			if (flush) begin
				// a pipeline flush abandons the half-fetched instruction
				state_next = ST_FIRST;
			end else if (accept) begin
				state_next  = ST_FIRST;
				valid_next  = 1'b1;
				second_next = instrWord;
				if (tabBranch) begin
					target_next = instrWord;
					taken_next  = condTaken;
				end
			end
		end
		default: begin
			state_next = ST_FIRST;
		end
		endcase
	end

	always @(posedge mclk) begin
		if (rst) begin
			state_reg        <= ST_FIRST;
			held_reg         <= 16'h0000;
			decodeValid      <= 1'b0;
			opSelect         <= `DMBD_OP_NONE;
			indirectMode     <= 1'b0;
			directAddr       <= 7'h00;
			immConst         <= 13'h0000;
			shiftField       <= 2'h0;
			twoWordOp        <= 1'b0;
			secondWord       <= 16'h0000;
			isBranch         <= 1'b0;
			branchTaken      <= 1'b0;
			branchTarget     <= 16'h0000;
			memRef           <= 1'b0;
			illegalOp        <= 1'b0;
			productShiftMode <= `DMBD_SHIFT_RESET;
		end else begin
			state_reg        <= state_next;
			held_reg         <= held_next;
			decodeValid      <= valid_next;
			opSelect         <= op_next;
			indirectMode     <= indirect_next;
			directAddr       <= addr_next;
			immConst         <= imm_next;
			shiftField       <= field_next;
			twoWordOp        <= two_next;
			secondWord       <= second_next;
			isBranch         <= branch_next;
			branchTaken      <= taken_next;
			branchTarget     <= target_next;
			memRef           <= memref_next;
			illegalOp        <= illegal_next;
			productShiftMode <= pshift_next;
		end
	end
endmodule

//--- verif/dmbd_checker.sv
// concurrent checks on the decoder ports
`timescale 1ns/10ps
`include "dmbd_regs.vh"

module dmbd_checker (
	input wire        mclk,
	input wire        rst,
	input wire [15:0] instrWord,
	input wire        instrValid,
	input wire        flush,
	input wire [31:0] accValue,
	input wire        wantSecond,
	input wire        decodeValid,
	input wire [5:0]  opSelect,
	input wire        indirectMode,
	input wire [6:0]  directAddr,
	input wire [12:0] immConst,
	input wire        twoWordOp,
	input wire [15:0] secondWord,
	input wire        isBranch,
	input wire        branchTaken,
	input wire [15:0] branchTarget,
	input wire [1:0]  productShiftMode
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence first_take;
		instrValid && !flush && !wantSecond;
	endsequence

	sequence second_take;
		instrValid && !flush && wantSecond;
	endsequence

	a_add_product: assert property (first_take ##0 instrWord == `DMBD_W_ADDPROD
		|=> decodeValid && opSelect == `DMBD_OP_ADDPROD && !twoWordOp)
		else $error("add product decode wrong");
	a_copy_product: assert property (first_take ##0 instrWord == `DMBD_W_LDACCPROD
		|=> decodeValid && opSelect == `DMBD_OP_LDACCPROD)
		else $error("copy product decode wrong");
	a_sub_product: assert property (first_take ##0 instrWord == `DMBD_W_SUBPROD
		|=> decodeValid && opSelect == `DMBD_OP_SUBPROD)
		else $error("subtract product decode wrong");
	a_field_copy: assert property (first_take ##0 instrWord[15:8] == `DMBD_U_LDPHI
		|=> directAddr == $past(instrWord[6:0]) && indirectMode == $past(instrWord[7]))
		else $error("address field not copied");
	a_mac_wait: assert property (first_take ##0 instrWord[15:8] == `DMBD_U_MULACC
		|=> wantSecond && !decodeValid)
		else $error("second word not requested");
	a_second_done: assert property (second_take
		|=> decodeValid && twoWordOp && secondWord == $past(instrWord))
		else $error("second word not completed");
	a_branch_target: assert property (second_take ##0 isBranch
		|=> branchTarget == $past(instrWord))
		else $error("branch target wrong");
	a_acc_branch: assert property (first_take ##0 instrWord == `DMBD_W_BRACC
		|=> branchTaken && branchTarget == $past(accValue[15:0]))
		else $error("accumulator branch wrong");
	a_shift_mode: assert property (first_take ##0 instrWord[15:2] == 14'h3382
		|=> productShiftMode == $past(instrWord[1:0]))
		else $error("shift mode not set");
	a_imm_const: assert property (first_take ##0 instrWord[15:13] == 3'h5
		|=> opSelect == `DMBD_OP_MULIMM && immConst == $past(instrWord[12:0]))
		else $error("immediate multiply wrong");
	a_flush_drop: assert property (flush |=> !decodeValid)
		else $error("flushed word decoded");
endmodule

//--- verif/dmbd_fetch_model.sv
// fetch side model offering instruction words to the decoder
`timescale 1ns/10ps

module dmbd_fetch_model (
	input  wire         mclk,
	output logic [15:0] instrWord,
	output logic        instrValid,
	output logic        flush
);
	initial begin
		instrWord = 16'h0000;
		instrValid = 1'b0;
		flush = 1'b0;
	end

	// word and strobe held until the taking edge has passed
	task send(input logic [15:0] w, input logic f);
		@(negedge mclk);
		instrWord = w;
		instrValid = 1'b1;
		flush = f;
		@(posedge mclk);
		#1;
	endtask

	// idle bus shows the inverted word so a stale value cannot decode by luck
	task idle;
		@(negedge mclk);
		instrValid = 1'b0;
		flush = 1'b0;
		instrWord = ~instrWord;
	endtask
endmodule

//--- verif/testbench.sv
// self-checking bench for the multiplier and branch group decoder
`timescale 1ns/10ps
`include "dmbd_regs.vh"

module testbench;
	logic        mclk;
	logic        rst;
	logic [31:0] accValue;
	logic        auxNonzero;
	logic        testControlFlag;
	logic        overflowFlag;
	logic        carryFlag;
	logic        ioStatus;
	wire  [15:0] instrWord;
	wire         instrValid;
	wire         flush;
	wire         instrReady;
	wire         wantSecond;
	wire         decodeValid;
	wire  [5:0]  opSelect;
	wire         indirectMode;
	wire  [6:0]  directAddr;
	wire  [12:0] immConst;
	wire  [1:0]  shiftField;
	wire         twoWordOp;
	wire  [15:0] secondWord;
	wire         isBranch;
	wire         branchTaken;
	wire  [15:0] branchTarget;
	wire         memRef;
	wire         illegalOp;
	wire  [1:0]  productShiftMode;
	int          fails;
	int          check_count;
	logic [15:0] wordTab [0:34] = '{16'hCE15, 16'hCE14, 16'hCE16, 16'h5380, 16'h3C00, 16'h3D00,
		16'h3E00, 16'h3F00, 16'h5B00, 16'h5D00, 16'h5C00, 16'h3800, 16'h3A00, 16'h3B00, 16'hCF00,
		16'hA123, 16'h3900, 16'h5A00, 16'h7D00, 16'h7C00, 16'hCE0B, 16'hCE25, 16'hFF80, 16'hFB80,
		16'hF480, 16'hF180, 16'hF280, 16'hF380, 16'hF580, 16'hF980, 16'hF880, 16'hF780, 16'h5E80,
		16'h5F80, 16'hFA80};
	logic [5:0]  opTab [0:34] = '{`DMBD_OP_ADDPROD, `DMBD_OP_LDACCPROD, `DMBD_OP_SUBPROD,
		`DMBD_OP_LDPHI, `DMBD_OP_LDMUL, `DMBD_OP_LDMULACC, `DMBD_OP_LDMULCPY, `DMBD_OP_LDMULMOV,
		`DMBD_OP_LDMULSUB, `DMBD_OP_MULACC, `DMBD_OP_MULACCMOV, `DMBD_OP_MUL, `DMBD_OP_MULADD,
		`DMBD_OP_MULSUB, `DMBD_OP_MULUNS, `DMBD_OP_MULIMM, `DMBD_OP_SQADD, `DMBD_OP_SQSUB,
		`DMBD_OP_STPHI, `DMBD_OP_STPLO, `DMBD_OP_SETSHIFT, `DMBD_OP_BRACC, `DMBD_OP_BUNC,
		`DMBD_OP_BAUX, `DMBD_OP_BNONNEG, `DMBD_OP_BPOS, `DMBD_OP_BNONPOS, `DMBD_OP_BNEG,
		`DMBD_OP_BNONZERO, `DMBD_OP_BFSET, `DMBD_OP_BFCLR, `DMBD_OP_BNOOVF, `DMBD_OP_BCSET,
		`DMBD_OP_BCCLR, `DMBD_OP_BIOLOW};

	dmbd_fetch_model fm (.mclk(mclk), .instrWord(instrWord), .instrValid(instrValid), .flush(flush));

	dmbd_decoder i_dut (.mclk(mclk), .rst(rst), .instrWord(instrWord), .instrValid(instrValid),
		.flush(flush), .accValue(accValue), .auxNonzero(auxNonzero),
		.testControlFlag(testControlFlag), .overflowFlag(overflowFlag), .carryFlag(carryFlag),
		.ioStatus(ioStatus), .instrReady(instrReady), .wantSecond(wantSecond),
		.decodeValid(decodeValid), .opSelect(opSelect), .indirectMode(indirectMode),
		.directAddr(directAddr), .immConst(immConst), .shiftField(shiftField),
		.twoWordOp(twoWordOp), .secondWord(secondWord), .isBranch(isBranch),
		.branchTaken(branchTaken), .branchTarget(branchTarget), .memRef(memRef),
		.illegalOp(illegalOp), .productShiftMode(productShiftMode));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task t_flags(input logic [31:0] a, input logic [4:0] f);
		@(negedge mclk);
		accValue = a;
		{auxNonzero, testControlFlag, overflowFlag, carryFlag, ioStatus} = f;
	endtask

	// every opcode once; takeVec holds the expected two-word branch outcomes, first such branch in the top bit
	task t_table(input logic [12:0] takeVec);
		logic two;
		for (int i = 0; i < 35; i++) begin
			two = (i == 9 || i == 10 || i > 21);
			fm.send(wordTab[i], 1'b0);
			if (two) begin
				chk(wantSecond, 1'b1);
				fm.send(16'h4000 + i[15:0], 1'b0);
				chk(secondWord, 16'h4000 + i[15:0]);
				chk(wantSecond, 1'b0);
			end
			chk(decodeValid, 1'b1);
			chk(opSelect, opTab[i]);
			chk(twoWordOp, two);
			chk(illegalOp, 1'b0);
			chk(isBranch, i > 20);
			chk(memRef, i > 2 && i < 20 && i != 15);
			if (i == 15) begin
				chk(immConst, 13'h0123);
			end
			if (i > 21) begin
				chk(branchTaken, takeVec[34 - i]);
				chk(branchTarget, 16'h4000 + i[15:0]);
			end
			if (i == 21) begin
				chk(branchTarget, accValue[15:0]);
				chk(branchTaken, 1'b1);
			end
			if (i == 20) begin
				chk(productShiftMode, 2'h3);
				chk(shiftField, 2'h3);
			end
			fm.idle();
			@(posedge mclk);
			#1;
			chk(decodeValid, 1'b0);
		end
	endtask

	// mid-run reset must clear the held shift mode left by the table runs
	task t_reset;
		@(negedge mclk);
		rst = 1'b1;
		@(posedge mclk);
		#1;
		chk(instrReady, 1'b0);
		chk(productShiftMode, `DMBD_SHIFT_RESET);
		chk(opSelect, `DMBD_OP_NONE);
		@(negedge mclk);
		rst = 1'b0;
		fm.send(16'hCE0A, 1'b0);
		chk(decodeValid, 1'b1);
		chk({shiftField, productShiftMode}, 4'hA);
		fm.idle();
	endtask

	// flushed first and second words, unknown word, then back-to-back one-word ops
	task t_refuse;
		fm.send(16'hCE15, 1'b1);
		chk(decodeValid, 1'b0);
		fm.send(16'hF480, 1'b0);
		fm.send(16'h1234, 1'b1);
		chk(decodeValid, 1'b0);
		chk(wantSecond, 1'b0);
		fm.send(16'hFF00, 1'b0);
		chk(illegalOp, 1'b1);
		chk(opSelect, `DMBD_OP_NONE);
		fm.send(16'h53A5, 1'b0);
		chk({indirectMode, directAddr}, 8'hA5);
		fm.send(16'hCE15, 1'b0);
		chk(opSelect, `DMBD_OP_ADDPROD);
		fm.send(16'hCE14, 1'b0);
		chk(opSelect, `DMBD_OP_LDACCPROD);
		fm.send(16'hCE16, 1'b0);
		chk(decodeValid, 1'b1);
		chk(opSelect, `DMBD_OP_SUBPROD);
		fm.idle();
	endtask

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// whole run needs well under two thousand cycles
	initial begin
		#20000;
		fails++;
		test_done();
	end

	initial begin
		fails = 0;
		check_count = 0;
		rst = 1'b1;
		accValue = 32'h00000000;
		{auxNonzero, testControlFlag, overflowFlag, carryFlag, ioStatus} = 5'h00;
		repeat (3) @(posedge mclk);
		#1;
		chk(instrReady, 1'b0);
		@(negedge mclk);
		rst = 1'b0;
		@(posedge mclk);
		#1;
		chk(instrReady, 1'b1);
		chk(opSelect, `DMBD_OP_NONE);
		t_flags(32'h8000ABCD, 5'h1F);
		t_table(13'h19E4);
		t_flags(32'h00000000, 5'h00);
		t_table(13'h151B);
		t_flags(32'h00001235, 5'h12);
		t_table(13'h1E5D);
		t_reset();
		t_refuse();
		test_done();
	end
endmodule

bind dmbd_decoder dmbd_checker i_chk (.mclk(mclk), .rst(rst), .instrWord(instrWord),
	.instrValid(instrValid), .flush(flush), .accValue(accValue), .wantSecond(wantSecond),
	.decodeValid(decodeValid), .opSelect(opSelect), .indirectMode(indirectMode),
	.directAddr(directAddr), .immConst(immConst), .twoWordOp(twoWordOp),
	.secondWord(secondWord), .isBranch(isBranch), .branchTaken(branchTaken),
	.branchTarget(branchTarget), .productShiftMode(productShiftMode));
